// ===== verilog/can_mob_filter.sv
// message-object mask filter, time stamp, data window and bit timing
`include "can_mob_cfg.svh"
module can_mob_filter
  import can_mob_pkg::*;
#(
  parameter int OBJ_W = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        frame_valid_i,
  input  wire rx_frame_t   frame_i,
  output logic             match_o,
  input  wire logic        rx_valid_i,
  input  wire rx_byte_t    rx_byte_i,
  output logic             rx_ready_o,
  output logic             bit_start_o,
  output logic             sample_o
);
  localparam int DEPTH = 2 ** (OBJ_W + 3);
  logic [OBJ_W+2:0] win_adr;
  logic [31:0] mask_r, tag_r;
  logic [7:0]  page_r, bt1_r, bt2_r, bt3_r;
  logic [15:0] stamp_cnt_r, stamp_r;
  logic [7:0]  mem [DEPTH];
  logic        take, bus_wr, win_wr, win_acc;
  logic [2:0]  idx_nxt;

  // --------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------
  // one cycle of latency; unmapped offsets answer with zero
  assign take    = cyc_i & stb_i & ~ack_o;
  assign bus_wr  = take & we_i;
  assign win_acc = take & (adr_i == `OFS_DATA);
  assign win_wr  = win_acc & we_i & sel_i[0];
  // object field and index, skipping the auto-increment bit between them
  assign win_adr = {page_r[7:`PAGE_OBJ_LSB], page_r[2:0]};
  function automatic logic [31:0] lanes(input logic [31:0] old);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (sel_i[b]) begin
        v[b*8 +: 8] = dat_i[b*8 +: 8];
      end
    end
    return v;
  endfunction : lanes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= take;
      if (take && !we_i) begin
        case (adr_i)
          `OFS_MASK: dat_o <= mask_r;
          `OFS_TAG:  dat_o <= tag_r;
          `OFS_STML: dat_o <= {24'h00_0000, stamp_r[7:0]};
          `OFS_STMH: dat_o <= {24'h00_0000, stamp_r[15:8]};
          `OFS_PAGE: dat_o <= {24'h00_0000, page_r};
          `OFS_DATA: dat_o <= {24'h00_0000, mem[win_adr]};
          `OFS_BT1:  dat_o <= {24'h00_0000, bt1_r};
          `OFS_BT2:  dat_o <= {24'h00_0000, bt2_r};
          `OFS_BT3:  dat_o <= {24'h00_0000, bt3_r};
          default:   dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= `MASK_RST;
      tag_r  <= `TAG_RST;
      bt1_r  <= `BT1_RST;
      bt2_r  <= `BT2_RST;
      bt3_r  <= `BT3_RST;
    end else if (bus_wr) begin
      // reserved bit 1 is stored as written; software keeps it zero
      if (adr_i == `OFS_MASK) mask_r <= lanes(mask_r);
      if (adr_i == `OFS_TAG)  tag_r  <= lanes(tag_r);
      if (adr_i == `OFS_BT1 && sel_i[0]) bt1_r <= dat_i[7:0];
      if (adr_i == `OFS_BT2 && sel_i[0]) bt2_r <= dat_i[7:0];
      if (adr_i == `OFS_BT3 && sel_i[0]) bt3_r <= dat_i[7:0];
    end
  end

  // --------------------------------------------------------------
  // page and data index
  // --------------------------------------------------------------
  assign idx_nxt = page_r[2:0] + 3'h1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_r <= `PAGE_RST;
    end else if (bus_wr && adr_i == `OFS_PAGE && sel_i[0]) begin
      page_r <= dat_i[7:0];
    end else if (win_acc && page_r[`PAGE_AINC_BIT]) begin
      page_r[2:0] <= idx_nxt;
    end
  end

  // --------------------------------------------------------------
  // receive buffer, two entries
  // --------------------------------------------------------------
  // bus writes to the window own the memory port, so draining waits
  rx_byte_t   fifo_r [2];
  logic       wp_r, rp_r;
  logic [1:0] cnt_r, cnt_nxt;
  logic       push, pop;
  logic [2:0] rx_idx_r, rx_idx;

  assign push = rx_valid_i & rx_ready_o;
  assign pop  = (cnt_r != 2'd0) & ~win_wr;
  assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r       <= 1'b0;
      rp_r       <= 1'b0;
      cnt_r      <= 2'd0;
      rx_ready_o <= 1'b0;
    end else begin
      cnt_r      <= cnt_nxt;
      rx_ready_o <= (cnt_nxt != 2'd2);
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      fifo_r[wp_r] <= rx_byte_i;
    end
  end

  assign rx_idx = fifo_r[rp_r].first ? 3'h0 : rx_idx_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_idx_r <= 3'h0;
    end else if (pop) begin
      rx_idx_r <= rx_idx + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (win_wr) begin
      mem[win_adr] <= dat_i[7:0];
    end else if (pop) begin
      mem[{fifo_r[rp_r].obj, rx_idx}] <= fifo_r[rp_r].data;
    end
  end

  // --------------------------------------------------------------
  // acceptance filter
  // --------------------------------------------------------------
  logic id_ok, rtr_ok, ide_ok;

  always_comb begin
    id_ok = 1'b1;
    if (frame_i.ide) begin
      for (int i = 0; i < `EXT_ID_W; i++) begin
        if (mask_r[`EXT_ID_LSB+i] && tag_r[`EXT_ID_LSB+i] != frame_i.id[i]) begin
          id_ok = 1'b0;
        end
      end
    end else begin
      for (int i = 0; i < `STD_ID_W; i++) begin
        if (mask_r[`STD_ID_LSB+i] && tag_r[`STD_ID_LSB+i] != frame_i.id[i]) begin
          id_ok = 1'b0;
        end
      end
    end
  end

  assign rtr_ok = ~mask_r[`RTR_BIT] | (tag_r[`RTR_BIT] == frame_i.rtr);
  assign ide_ok = ~mask_r[`IDE_BIT] | (tag_r[`IDE_BIT] == frame_i.ide);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_o <= 1'b0;
    end else begin
      match_o <= frame_valid_i & id_ok & rtr_ok & ide_ok;
    end
  end

  // --------------------------------------------------------------
  // bit timing
  // --------------------------------------------------------------
  // segments are stored as length minus one, hence the plus terms
  logic [5:0] presc_r, presc_top;
  logic [4:0] tq_r, sp_last, bit_last;
  logic       tq_end;

  assign presc_top = bt1_r[`BT_PRS_LSB +: 6];
  assign sp_last   = 5'(bt2_r[`BT_PRS_LSB +: 3]) + 5'(bt3_r[`BT_PRS_LSB +: 3])
                     + 5'd2;
  assign bit_last  = sp_last + 5'(bt3_r[`BT_PH2_LSB +: 3]) + 5'd1;
  assign tq_end    = (presc_r == presc_top);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_r     <= 6'h00;
      tq_r        <= 5'h00;
      bit_start_o <= 1'b0;
      sample_o    <= 1'b0;
    end else begin
      presc_r     <= tq_end ? 6'h00 : presc_r + 6'h01;
      bit_start_o <= tq_end & (tq_r >= bit_last);
      sample_o    <= tq_end & (tq_r == sp_last);
      if (tq_end) begin
        tq_r <= (tq_r >= bit_last) ? 5'h00 : tq_r + 5'h01;
      end
    end
  end

  // --------------------------------------------------------------
  // time stamp
  // --------------------------------------------------------------
  // counts nominal bit times; wraps at the top of the 16-bit range
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stamp_cnt_r <= 16'h0000;
      stamp_r     <= 16'h0000;
    end else begin
      if (bit_start_o) begin
        stamp_cnt_r <= stamp_cnt_r + 16'h0001;
      end
      if (push && rx_byte_i.first) begin
        stamp_r <= stamp_cnt_r;
      end
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  logic [15:0] sp_clk_r;
  logic        tm_dirty_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_clk_r   <= 16'h0000;
      tm_dirty_r <= 1'b1;
    end else begin
      sp_clk_r <= bit_start_o ? 16'h0001 : sp_clk_r + 16'h0001;
      if (bus_wr && adr_i >= `OFS_BT1) begin
        tm_dirty_r <= 1'b1;
      end else if (bit_start_o) begin
        tm_dirty_r <= 1'b0;
      end
    end
  end

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i) take |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack");

  property p_idx_inc;
    @(posedge clk_i) disable iff (rst_i)
      win_acc && page_r[`PAGE_AINC_BIT]
      |=> page_r[2:0] == $past(page_r[2:0]) + 3'h1;
  endproperty
  a_idx_inc: assert property (p_idx_inc) else $error("index stuck");

  property p_idx_wrap;
    @(posedge clk_i) disable iff (rst_i)
      win_acc && page_r[`PAGE_AINC_BIT] && page_r[2:0] == 3'h7
      |=> page_r[2:0] == 3'h0;
  endproperty
  a_idx_wrap: assert property (p_idx_wrap) else $error("no wrap");

  property p_idx_hold;
    @(posedge clk_i) disable iff (rst_i)
      win_acc && !page_r[`PAGE_AINC_BIT] |=> $stable(page_r);
  endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("index moved");

  property p_page_set;
    @(posedge clk_i) disable iff (rst_i)
      bus_wr && adr_i == `OFS_PAGE && sel_i[0] |=> page_r == $past(dat_i[7:0]);
  endproperty
  a_page_set: assert property (p_page_set) else $error("page lost");

  property p_open_mask;
    @(posedge clk_i) disable iff (rst_i)
      frame_valid_i && mask_r == 32'h0000_0000 |=> match_o;
  endproperty
  a_open_mask: assert property (p_open_mask) else $error("no match");

  property p_rtr_cmp;
    @(posedge clk_i) disable iff (rst_i)
      frame_valid_i && mask_r[`RTR_BIT] && tag_r[`RTR_BIT] != frame_i.rtr
      |=> !match_o;
  endproperty
  a_rtr_cmp: assert property (p_rtr_cmp) else $error("rtr passed");

  property p_stamp_ro;
    @(posedge clk_i) disable iff (rst_i)
      bus_wr && !(push && rx_byte_i.first) |=> $stable(stamp_r);
  endproperty
  a_stamp_ro: assert property (p_stamp_ro) else $error("stamp written");

  property p_full_stall;
    @(posedge clk_i) disable iff (rst_i) cnt_r == 2'd2 |-> !rx_ready_o;
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("overfill");

  property p_sample_pos;
    @(posedge clk_i) disable iff (rst_i)
      sample_o && !tm_dirty_r
      |-> sp_clk_r == 16'(sp_last + 5'd1) * 16'(presc_top + 6'd1);
  endproperty
  a_sample_pos: assert property (p_sample_pos) else $error("sample off");

  property p_c_wrap;
    @(posedge clk_i) disable iff (rst_i)
      win_acc && page_r[2:0] == 3'h7 && page_r[`PAGE_AINC_BIT];
  endproperty
  c_wrap: cover property (p_c_wrap);

  property p_c_full;
    @(posedge clk_i) disable iff (rst_i) cnt_r == 2'd2 && rx_valid_i;
  endproperty
  c_full: cover property (p_c_full);

  property p_c_match;
    @(posedge clk_i) disable iff (rst_i) match_o && mask_r != 32'h0000_0000;
  endproperty
  c_match: cover property (p_c_match);

endmodule : can_mob_filter

// ===== verilog/can_mob_cfg.svh
// register map, field positions, reset values of the message-object block
`ifndef CAN_MOB_CFG_SVH
`define CAN_MOB_CFG_SVH
`define OFS_MASK      8'h00
`define OFS_TAG       8'h04
`define OFS_STML      8'h08
`define OFS_STMH      8'h0c
`define OFS_PAGE      8'h10
`define OFS_DATA      8'h14
`define OFS_BT1       8'h18
`define OFS_BT2       8'h1c
`define OFS_BT3       8'h20
`define EXT_ID_LSB    3
`define STD_ID_LSB    21
`define RTR_BIT       2
`define RSV_BIT       1
`define IDE_BIT       0
`define PAGE_AINC_BIT 3
`define PAGE_OBJ_LSB  4
`define BT_PRS_LSB    1
`define BT_PH2_LSB    4
`define MASK_RST      32'h0000_0000
`define TAG_RST       32'h0000_0000
`define PAGE_RST      8'h00
`define BT1_RST       8'h00
`define BT2_RST       8'h0c
`define BT3_RST       8'h37
`define STD_ID_W      11
`define EXT_ID_W      29
`endif

// ===== verilog/can_mob_pkg.sv
// types shared by the message-object block
package can_mob_pkg;
  typedef struct packed {
    logic [28:0] id;
    logic        rtr;
    logic        ide;
  } rx_frame_t;
  typedef struct packed {
    logic [3:0] obj;
    logic       first;
    logic [7:0] data;
  } rx_byte_t;
endpackage : can_mob_pkg

// ===== tb/can_node_model.sv
// far-side node model: offers received bytes on the rx stream
module can_node_model
  import can_mob_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rx_ready_i,
  output logic      rx_valid_o,
  output rx_byte_t  rx_byte_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o  = '0;
  end
  // holds the byte until taken; afterwards shows the inverse, not stale data
  task automatic send(input rx_byte_t b, input int stall);
    repeat (stall) @(posedge clk_i);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_byte_o  <= b;
    do @(posedge clk_i); while (rx_ready_i !== 1'b1);
    rx_valid_o <= 1'b0;
    rx_byte_o  <= ~b;
  endtask : send
endmodule : can_node_model

// ===== tb/tb_can_mob_filter_stamp_data_access.sv
// self-checking bench of the message-object block
`include "can_mob_cfg.svh"
module tb_can_mob_filter_stamp_data_access
  import can_mob_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, m, t;
  logic ack_o, frame_valid_i = 0, match_o, rx_valid_i, rx_ready_o;
  logic bit_start_o, sample_o, fv_d = 0;
  rx_frame_t frame_i = '0;
  rx_byte_t rx_byte_i;
  logic [31:0] rd_q[$];
  logic mt_q[$];
  logic [7:0] mm[0:7];
  int checked = 0, miscompares = 0, cycles = 0;
  logic [15:0] bs_cnt, st;
  always #25 clk_i = ~clk_i;
  can_mob_filter i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .frame_valid_i(frame_valid_i),
    .frame_i(frame_i), .match_o(match_o), .rx_valid_i(rx_valid_i),
    .rx_byte_i(rx_byte_i), .rx_ready_o(rx_ready_o),
    .bit_start_o(bit_start_o), .sample_o(sample_o));
  can_node_model u_node (.clk_i(clk_i), .rx_ready_i(rx_ready_o),
    .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      wrap_up();
    end
  end
  always @(posedge clk_i) begin
    fv_d <= frame_valid_i;
    if (ack_o === 1'b1 && we_i === 1'b0) chk(dat_o, rd_q.pop_front());
    if (fv_d) chk(match_o, mt_q.pop_front());
    if (rst_i) bs_cnt <= '0;
    else if (bit_start_o === 1'b1) bs_cnt <= bs_cnt + 16'h1;
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w;
    adr_i <= a; dat_i <= d; sel_i <= s;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    cyc_i <= 1'b0; stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, (a < 8'h08) ? 4'hf : 4'h1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask : rd
  function automatic logic exp_match(input logic [31:0] mk, tg,
                                     input rx_frame_t f);
    logic ok;
    if (f.ide) ok = (((f.id ^ tg[31:3]) & mk[31:3]) == 29'h0);
    else ok = (((f.id[10:0] ^ tg[31:21]) & mk[31:21]) == 11'h0);
    return ok && !(mk[2] && f.rtr != tg[2]) && !(mk[0] && f.ide != tg[0]);
  endfunction : exp_match
  task automatic tmeas(input int eb, input int es);
    int n;
    n = 0;
    repeat (2) do @(posedge clk_i); while (bit_start_o !== 1'b1);
    do begin @(posedge clk_i); n++; end while (sample_o !== 1'b1 && n < 99);
    chk(n, es);
    do begin @(posedge clk_i); n++; end while (bit_start_o !== 1'b1 && n < 99);
    chk(n, eb);
  endtask : tmeas
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rx_frame_t f;
    logic [7:0] d;
    void'($urandom(32'h66b48c42));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFS_BT1, 32'h00); rd(`OFS_BT2, 32'h0c); rd(`OFS_BT3, 32'h37);
    rd(`OFS_MASK, 32'h0); rd(`OFS_PAGE, 32'h0); rd(`OFS_STML, 32'h0);
    rd(8'h24, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 41; i++) begin
      t = $urandom & 32'hffff_fffd;
      // last pass opens the mask fully, so every frame must be accepted
      m = (i == 40) ? 32'h0 : ($urandom & 32'hffff_fffd);
      wr(`OFS_TAG, t); wr(`OFS_MASK, m);
      f.ide = $urandom;
      f.id = (f.ide ? t[31:3] : {18'h0, t[31:21]}) ^ ($urandom & $urandom);
      f.rtr = t[2] ^ ($urandom % 4 == 0);
      @(posedge clk_i);
      frame_valid_i <= 1'b1; frame_i <= f;
      mt_q.push_back(exp_match(m, t, f));
      @(posedge clk_i);
      frame_valid_i <= 1'b0;
    end
    $display("test filter done");
    wr(`OFS_PAGE, 8'h2e);
    for (int k = 0; k < 10; k++) begin
      d = $urandom; mm[(6 + k) % 8] = d; wr(`OFS_DATA, d);
    end
    wr(`OFS_PAGE, 8'h2e);
    for (int k = 0; k < 10; k++) rd(`OFS_DATA, mm[(6 + k) % 8]);
    wr(`OFS_PAGE, 8'h23);
    rd(`OFS_DATA, mm[3]); rd(`OFS_DATA, mm[3]);
    $display("test window done");
    do @(posedge clk_i); while (bit_start_o !== 1'b1);
    st = bs_cnt + 16'h1;
    for (int k = 0; k < 8; k++) begin
      mm[k] = $urandom;
      u_node.send({4'h5, k == 0, mm[k]}, k % 3);
    end
    repeat (4) @(posedge clk_i);
    wr(`OFS_STML, 32'hff); // read-only place, write must not land
    rd(`OFS_STML, st[7:0]); rd(`OFS_STMH, st[15:8]);
    wr(`OFS_PAGE, 8'h58);
    for (int k = 0; k < 8; k++) rd(`OFS_DATA, mm[k]);
    $display("test stamp and stream done");
    tmeas(16, 12);
    wr(`OFS_BT1, 8'h04); wr(`OFS_BT2, 8'h04); wr(`OFS_BT3, 8'h13);
    tmeas(24, 18);
    wr(`OFS_BT1, 8'h00); wr(`OFS_BT2, 8'h0c); wr(`OFS_BT3, 8'h37);
    tmeas(16, 12);
    $display("test bit timing done");
    repeat (4) @(posedge clk_i);
    wrap_up();
  end
endmodule : tb_can_mob_filter_stamp_data_access
